/* design/vrlk_regs.svh */
// Offsets, field positions, reset values and timing counts for the lock and maker configuration bank.
// Assumes a 100 MHz device clock and an SMBus byte engine that presents decoded command-code accesses.
`ifndef VRLK_REGS_SVH
`define VRLK_REGS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define VRLK_CMD_PROTECT_AND_RESTORE 8'hD0
`define VRLK_CMD_MAKER_CONFIGURATION 8'hD1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VRLK_RST_PROTECT_AND_RESTORE 8'h00
`define VRLK_RST_MAKER_CONFIGURATION 8'h03

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VRLK_BIT_LOCK         0
`define VRLK_BIT_RESTORE      1
`define VRLK_BIT_MONITOR_EN   0
`define VRLK_BIT_ALERT_EN     1
`define VRLK_BIT_TIMEOUT_EN   3
`define VRLK_BIT_ALERT_COMP   4
`define VRLK_BIT_PHASE_LO     6
`define VRLK_BIT_PHASE_HI     7
`define VRLK_MAKER_WRITE_MASK 8'hDB

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VRLK_CLK_MHZ          100
`define VRLK_TIMEOUT_MS       35
`define VRLK_TIMEOUT_CYCLES   (`VRLK_TIMEOUT_MS * 1000 * `VRLK_CLK_MHZ)

`endif

/* design/vrlk_pkg.sv */
// Types shared by the lock and maker configuration bank.
// Assumes vrlk_regs.svh supplies the numeric constants.
package vrlk_pkg;

  // Register access as decoded by the SMBus byte engine.
  typedef struct packed
  {
    logic       wr_valid;
    logic       rd_valid;
    logic [7:0] code;
    logic [7:0] wdata;
  } vrlk_access_type;

  // Fields of the maker configuration register put to use.
  typedef struct packed
  {
    logic [1:0] power_save_phase_count;
    logic       alert_comparator_mode;
    logic       bus_hang_timeout_enable;
    logic       alert_enable;
    logic       monitor_enable;
  } vrlk_config_type;

  typedef enum logic [2:0]
  {
    VRLK_IDLE = 3'b001,
    VRLK_BUSY = 3'b010,
    VRLK_HUNG = 3'b100
  } vrlk_watch_type;

endpackage

/* design/vrlk_hang_watch.sv */
// Bus-hang watchdog: counts idle time inside a transaction and requests release.
// Assumes the SMBus engine reports activity and transaction span as clocked levels.
`timescale 1ns/1ps
`include "vrlk_regs.svh"
module vrlk_hang_watch
#(
  parameter int unsigned LIMIT = `VRLK_TIMEOUT_CYCLES
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic enable,
  input  wire logic in_transaction,
  input  wire logic bus_activity,
  // Result
  output logic      release_bus
);
  import vrlk_pkg::*;

  vrlk_watch_type state;
  logic [31:0]    idle_count;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      idle_count <= 32'h0;
    else if (state != VRLK_BUSY || bus_activity)
      idle_count <= 32'h0;
    else
      idle_count <= idle_count + 32'h1;
  end

  // A hang is declared once the idle count reaches the limit.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= VRLK_IDLE;
    else
      unique case (state)
        VRLK_IDLE: if (enable && in_transaction) state <= VRLK_BUSY;
        VRLK_BUSY:
          if (!enable || !in_transaction)
            state <= VRLK_IDLE;
          else if (!bus_activity && idle_count >= LIMIT)
            state <= VRLK_HUNG; // see RQ7
        VRLK_HUNG: state <= VRLK_IDLE;
        default:   state <= VRLK_IDLE;
      endcase
  end

  assign release_bus = (state == VRLK_HUNG);
endmodule

/* design/vrlk_config_bank.sv */
// Lock/restore and maker configuration registers reached by SMBus command code.
// Assumes an SMBus byte engine decodes one-byte accesses and pulses wr_valid or rd_valid.
// Function
// RQ1: Writing one to restore bit returns every register to power-on value.
// RQ2: Restore request is ignored while the protect latch is set.
// RQ3: Writing one to lock bit freezes all limit values; the code ignores the lock bit when the restore bit is also written as one.
// RQ4: Once locked, lockable registers including the latch are read-only until power cycle.
// RQ5: Bits 7:6 select power-save phase count: 00 one, 01 two, 10 three, 11 one.
// RQ6: Bit 4 selects comparator alert (1) or latched alert (0).
// RQ7: Bit 3 enables 35 ms bus-hang release; that bit is lockable.
// RQ8: Bit 1 gates the alert output pin.
// RQ9: Bit 0 enables ADC conversions and monitoring.
// RQ10: Bits 5 and 2 are reserved and have no function.
// RQ11: One-byte read or write by command code; reads return current contents.
`timescale 1ns/1ps
`include "vrlk_regs.svh"
module vrlk_config_bank
#(
  parameter int unsigned TIMEOUT_CYCLES = `VRLK_TIMEOUT_CYCLES
)
(
  // Clock and power-on reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Register access from the SMBus engine
  input  vrlk_pkg::vrlk_access_type access,
  output logic [7:0]                rdata,
  output logic                      rdata_valid,
  output logic                      code_hit,
  // SMBus engine status
  input  wire logic                 in_transaction,
  input  wire logic                 bus_activity,
  output logic                      bus_release,
  // Alert source and pin
  input  wire logic                 alert_event,
  output logic                      alert_pin,
  // Controls to the rest of the regulator
  output vrlk_pkg::vrlk_config_type config_out,
  output logic [1:0]                power_save_phases,
  output logic                      limits_locked,
  output logic                      restore_all
);
  import vrlk_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic       locked;
  logic [7:0] maker;
  logic       alert_latched;
  logic       wr_protect;
  logic       wr_maker;
  logic       restore_req;

  function automatic logic [1:0] phases_of(input logic [1:0] code);
    unique case (code)
      2'b01:   phases_of = 2'h2;
      2'b10:   phases_of = 2'h3;
      default: phases_of = 2'h1;
    endcase
  endfunction

  assign wr_protect  = access.wr_valid && access.code == `VRLK_CMD_PROTECT_AND_RESTORE;
  assign wr_maker    = access.wr_valid && access.code == `VRLK_CMD_MAKER_CONFIGURATION;
  // The restore bit is self-clearing: it fires one cycle, never stored.
  assign restore_req = wr_protect && access.wdata[`VRLK_BIT_RESTORE] && !locked; // see RQ2

  // Only a power-on reset clears the latch; restore deliberately leaves it alone.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      locked <= 1'b0;
    else if (wr_protect && !locked && !access.wdata[`VRLK_BIT_RESTORE])
      locked <= access.wdata[`VRLK_BIT_LOCK]; // see RQ3, RQ4
  end

  // A locked bank refuses maker writes too, so the hang enable cannot change.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      maker <= `VRLK_RST_MAKER_CONFIGURATION;
    else if (restore_req)
      maker <= `VRLK_RST_MAKER_CONFIGURATION; // see RQ1
    else if (wr_maker && !locked)
      maker <= access.wdata & `VRLK_MAKER_WRITE_MASK; // see RQ4, RQ7, RQ10
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= access.rd_valid && code_hit;
      if (access.rd_valid)
        unique case (access.code)
          `VRLK_CMD_PROTECT_AND_RESTORE: rdata <= {7'h00, locked}; // see RQ11
          `VRLK_CMD_MAKER_CONFIGURATION: rdata <= maker;           // see RQ11
          default:                       rdata <= 8'h00;
        endcase
    end
  end

  assign code_hit = access.code == `VRLK_CMD_PROTECT_AND_RESTORE ||
                    access.code == `VRLK_CMD_MAKER_CONFIGURATION;

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  assign config_out.power_save_phase_count  = maker[`VRLK_BIT_PHASE_HI:`VRLK_BIT_PHASE_LO];
  assign config_out.alert_comparator_mode   = maker[`VRLK_BIT_ALERT_COMP];
  assign config_out.bus_hang_timeout_enable = maker[`VRLK_BIT_TIMEOUT_EN];
  assign config_out.alert_enable            = maker[`VRLK_BIT_ALERT_EN];
  assign config_out.monitor_enable          = maker[`VRLK_BIT_MONITOR_EN]; // see RQ9
  assign power_save_phases = phases_of(config_out.power_save_phase_count); // see RQ5
  assign limits_locked     = locked;
  assign restore_all       = restore_req; // see RQ1

  // ----------------------------------------------------------------
  // Alert output
  // ----------------------------------------------------------------
  // Latched mode holds the alert until a read of this bank or a restore; comparator follows the source.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      alert_latched <= 1'b0;
    else if (alert_event)
      alert_latched <= 1'b1;
    else if (access.rd_valid && code_hit || restore_req)
      alert_latched <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      alert_pin <= 1'b0;
    else
      alert_pin <= config_out.alert_enable && // see RQ8
                   (config_out.alert_comparator_mode ? alert_event : alert_latched); // see RQ6
  end

  // ----------------------------------------------------------------
  // Bus-hang watchdog
  // ----------------------------------------------------------------
  vrlk_hang_watch
  #(
    .LIMIT (TIMEOUT_CYCLES)
  )
  u_hang_watch
  (
    .clk            (clk),
    .rst_b          (rst_b),
    .enable         (config_out.bus_hang_timeout_enable), // see RQ7
    .in_transaction (in_transaction),
    .bus_activity   (bus_activity),
    .release_bus    (bus_release)
  );
endmodule

/* test/vrlk_monitor.sv */
// Port checks for the lock and maker configuration bank.
// Assumes one clock domain and a hang limit handed down by the bind.
`timescale 1ns/1ps
module vrlk_monitor
#(
  parameter int unsigned LIMIT = 20
)
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // Register access
  input vrlk_pkg::vrlk_access_type  access,
  input wire logic [7:0]            rdata,
  input wire logic                  rdata_valid,
  input wire logic                  code_hit,
  // Bus status
  input wire logic                  in_transaction,
  input wire logic                  bus_activity,
  input wire logic                  bus_release,
  // Alert
  input wire logic                  alert_event,
  input wire logic                  alert_pin,
  // Controls
  input vrlk_pkg::vrlk_config_type  config_out,
  input wire logic [1:0]            power_save_phases,
  input wire logic                  limits_locked,
  input wire logic                  restore_all
);
  import vrlk_pkg::*;
  int unsigned idle;
  logic [1:0]  pcode;
  logic [7:0]  cfg_byte;
  // Register image rebuilt from the field outputs; reserved bits read as zero.
  assign pcode    = config_out.power_save_phase_count;
  assign cfg_byte = {config_out[5:4], 1'b0, config_out[3:2], 1'b0, config_out[1:0]};
  // Idle time spent inside a transaction with the watchdog armed.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      idle <= 0;
    else if (bus_release || !(in_transaction && !bus_activity && config_out[2]))
      idle <= 0;
    else
      idle <= idle + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence d0_write;
    access.wr_valid && access.code == 8'hD0;
  endsequence
  sequence restore_req;
    d0_write and access.wdata[1] && !limits_locked;
  endsequence
  restore_apply_a: assert property (restore_req |-> restore_all ##1 config_out == 6'h03)
    else $error("restore did not reload defaults");
  restore_block_a: assert property (limits_locked |-> !restore_all)
    else $error("restore taken while locked");
  lock_set_a: assert property (d0_write and access.wdata[1:0] == 2'b01 |=> limits_locked)
    else $error("lock not set");
  lock_hold_a: assert property (limits_locked |=> limits_locked && $stable(config_out))
    else $error("locked state changed");
  phase_map_a: assert property (power_save_phases == ((pcode == 2'b11) ? 2'b01 : pcode + 2'b01))
    else $error("phase decode wrong");
  comp_follow_a: assert property (config_out[3] && config_out[1] |=> alert_pin == $past(alert_event))
    else $error("comparator alert wrong");
  alert_gate_a: assert property (!config_out[1] |=> !alert_pin)
    else $error("alert pin not gated");
  hang_early_a: assert property (bus_release |-> config_out[2] && idle > LIMIT)
    else $error("bus released early");
  hang_late_a: assert property (idle <= LIMIT + 2)
    else $error("bus not released");
  read_data_a: assert property (access.rd_valid && access.code == 8'hD1 |=> rdata_valid && rdata == $past(cfg_byte))
    else $error("read data wrong");
  hit_decode_a: assert property (code_hit == (access.code == 8'hD0 || access.code == 8'hD1))
    else $error("command decode wrong");
  unmapped_a: assert property (access.rd_valid && !code_hit |=> !rdata_valid && rdata == 8'h00)
    else $error("unmapped read answered");
endmodule
bind vrlk_config_bank vrlk_monitor #(.LIMIT(TIMEOUT_CYCLES)) u_vrlk_monitor (.clk(clk), .rst_b(rst_b),
  .access(access), .rdata(rdata), .rdata_valid(rdata_valid), .code_hit(code_hit), .in_transaction(in_transaction),
  .bus_activity(bus_activity), .bus_release(bus_release), .alert_event(alert_event), .alert_pin(alert_pin),
  .config_out(config_out), .power_save_phases(power_save_phases), .limits_locked(limits_locked),
  .restore_all(restore_all));

/* test/vrlk_host.sv */
// SMBus host model issuing one-byte command-code accesses.
// Assumes the bank takes a one-cycle valid on the rising edge.
`timescale 1ns/1ps
module vrlk_host
(
  // Clock
  input wire logic                  clk,
  // Access toward the bank
  output vrlk_pkg::vrlk_access_type access
);
  import vrlk_pkg::*;
  initial access = '0;
  // Idle fields show the inverse byte so a stale value never passes as live.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] data);
    @(negedge clk);
    access = '{wr, !wr, code, data};
    @(negedge clk);
    access = '{1'b0, 1'b0, ~code, ~data};
  endtask
endmodule

/* test/vr_lock_and_mfr_config_regs_tb.sv */
// Self-checking bench for the configuration bank against a bench model.
// Assumes the host model and a hang limit shortened to LIM cycles.
`timescale 1ns/1ps
module vr_lock_and_mfr_config_regs_tb;
  import vrlk_pkg::*;
  localparam int LIM = 20;
  logic clk = 0, rst_b = 0, in_tr = 0, aev = 0, act = 0, rdv, hit, rel, apin, lck, rall;
  logic [7:0] rdata, em, d;
  logic [1:0] psp;
  logic [31:0] seed = 54;
  vrlk_access_type acc;
  vrlk_config_type cfg;
  int n_fail = 0, n_compared = 0;
  vrlk_host u_vrlk_host (.clk(clk), .access(acc));
  vrlk_config_bank #(.TIMEOUT_CYCLES(LIM)) u_vrlk_config_bank (.clk(clk), .rst_b(rst_b), .access(acc),
    .rdata(rdata), .rdata_valid(rdv), .code_hit(hit), .in_transaction(in_tr), .bus_activity(act),
    .bus_release(rel), .alert_event(aev), .alert_pin(apin), .config_out(cfg), .power_save_phases(psp),
    .limits_locked(lck), .restore_all(rall));
  initial forever #5 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] c, input logic [7:0] exp);
    u_vrlk_host.xfer(1'b0, c, 8'h00);
    chk(rdata, exp);
    chk({7'h00, rdv}, {7'h00, c[7:1] == 7'h68});
  endtask
  task wr(input logic [7:0] c, input logic [7:0] v);
    u_vrlk_host.xfer(1'b1, c, v);
  endtask
  // A nonzero gap pulses bus activity every gap cycles, which must keep the watchdog quiet.
  task hang(input logic [7:0] exp, input int gap);
    d = 0;
    in_tr = 1;
    for (int k = 1; k <= LIM + 5; k++)
    begin
      @(negedge clk);
      act = (gap > 0) && (k % gap == 0);
      if (rel !== 1'b0) d = 1;
    end
    in_tr = 0;
    act = 0;
    chk(d, exp);
  endtask
  task summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_b = 1;
    rd(8'hD1, 8'h03);
    rd(8'hD0, 8'h00);
    rd(8'h7E, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      d = (rnd() & 8'h3F) | 8'(i << 6);
      wr(8'hD1, d);
      em = d & 8'hDB;
      chk({6'h00, psp}, (em[7:6] == 2'b11) ? 8'h01 : {6'h00, em[7:6]} + 8'h01);
      chk({2'b00, cfg}, {2'b00, em[7:6], em[4:3], em[1:0]});
      rd(8'hD1, em);
    end
    $display("config test done");
    wr(8'hD1, 8'h1A);
    aev = 1;
    @(negedge clk);
    chk({7'h00, apin}, 8'h01);
    aev = 0;
    @(negedge clk);
    chk({7'h00, apin}, 8'h00);
    wr(8'hD1, 8'h0A);
    // The comparator pass left the latch set; a read must clear it before the latched check.
    rd(8'hD1, 8'h0A);
    @(negedge clk);
    chk({7'h00, apin}, 8'h00);
    aev = 1;
    @(negedge clk);
    aev = 0;
    repeat (2) @(negedge clk);
    chk({7'h00, apin}, 8'h01);
    rd(8'hD1, 8'h0A);
    @(negedge clk);
    chk({7'h00, apin}, 8'h00);
    wr(8'hD1, 8'h08);
    aev = 1;
    repeat (2) @(negedge clk);
    chk({7'h00, apin}, 8'h00);
    aev = 0;
    $display("alert test done");
    hang(8'h01, 0);
    hang(8'h00, LIM / 2);
    wr(8'hD1, 8'h00);
    hang(8'h00, 0);
    $display("hang test done");
    wr(8'hD1, 8'hDB);
    wr(8'hD0, 8'h02);
    rd(8'hD1, 8'h03);
    rd(8'hD0, 8'h00);
    // A non-default image makes a wrongly taken restore visible after locking.
    wr(8'hD1, 8'h5A);
    wr(8'hD0, 8'h01);
    chk({7'h00, lck}, 8'h01);
    wr(8'hD1, 8'hC8);
    wr(8'hD0, 8'h02);
    wr(8'hD0, 8'h00);
    rd(8'hD1, 8'h5A);
    rd(8'hD0, 8'h01);
    hang(8'h01, 0);
    $display("lock test done");
    rst_b = 0;
    repeat (2) @(negedge clk);
    rst_b = 1;
    chk({7'h00, lck}, 8'h00);
    rd(8'hD1, 8'h03);
    rd(8'hD0, 8'h00);
    $display("reset test done");
    summarize();
  end
endmodule
